// *** rccs_regs.svh ***
`ifndef RCCS_REGS_SVH
`define RCCS_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RCCS_OFS_CTRL 12'h000
`define RCCS_OFS_STATUS 12'h004
`define RCCS_OFS_CODES 12'h008

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define RCCS_CTRL_START 0
`define RCCS_CTRL_CANCEL 1
`define RCCS_CTRL_RESTART 2
`define RCCS_CTRL_REPEAT 3
`define RCCS_CTRL_FAILED 4
`define RCCS_CTRL_PRESENCE 5
`define RCCS_CTRL_ECC 6
`define RCCS_CTRL_CODE_LO 8
`define RCCS_CTRL_CODE_HI 15

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define RCCS_ST_READY 0
`define RCCS_ST_ACTIVE 1
`define RCCS_ST_ERROR 2
`define RCCS_ST_ADVANCE 3
`define RCCS_ST_RESTART 4
`define RCCS_ST_TAG 5
`define RCCS_ST_ABORT 6
`define RCCS_ST_CORRECTED 7
`define RCCS_ST_BAT_DEAD 8
`define RCCS_ST_BAT_LOW 9
`define RCCS_ST_CANCELING 10

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define RCCS_MOD_ERR_DOWN 8'h0f
`define RCCS_FN_ERR_FAILED 8'h09
`define RCCS_CMD_ADVANCE 8'h0b
`define RCCS_CODE_NONE 8'h00

`endif

// *** rccs_pkg.sv ***
package rccs_pkg;

  // Channel operating mode
  typedef enum logic [1:0] {
    RCCS_IDLE = 2'b00,
    RCCS_RUN = 2'b01,
    RCCS_CANCEL = 2'b10,
    RCCS_RESTART = 2'b11
  } rccs_mode_t;

  // State of the channel logic, apart from the synchronisers and the sticky error and abort flags
  typedef struct packed {
    rccs_mode_t mode;
    logic [7:0] cmd_code;
    logic cmd_pulse;
    logic ready;
    logic active;
    logic last_adv;
    logic last_rst;
    logic tag_pres;
    logic corrected;
    logic bat_dead;
    logic bat_low;
    logic repeat_en;
    logic presence_en;
    logic ecc_en;
    logic mod_failed;
    logic [7:0] mod_code;
    logic [7:0] fn_code;
    logic [7:0] bus_code;
    logic ack_q;
    logic cack_q;
    logic merr_q;
    logic mdown_q;
    logic berr_q;
    logic pload_q;
    logic [31:0] prdata;
  } rccs_state_t;

endpackage

// *** rccs_sync.sv ***
`timescale 1ns/1ps
`include "rccs_regs.svh"

module rccs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } rccs_sync_t;

  rccs_sync_t s_r;
  rccs_sync_t s_nxt;

  // Meta stage feeds only the second stage
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = async_i;
    s_nxt.sync = s_r.meta;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = s_r.sync;

endmodule

// *** rccs_flag.sv ***
`timescale 1ns/1ps

module rccs_flag (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Set and clear strobes
  input wire logic set_i,
  input wire logic clr_i,
  // Sticky flag
  output logic flag_o
);

  typedef struct packed {
    logic flag;
  } rccs_flag_t;

  rccs_flag_t s_r;
  rccs_flag_t s_nxt;

  // Set wins so a coinciding event is never lost
  always_comb begin
    s_nxt = s_r;
    s_nxt.flag = set_i | (s_r.flag & ~clr_i);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flag_o = s_r.flag;

endmodule

// *** rccs_channel.sv ***
`timescale 1ns/1ps
`include "rccs_regs.svh"

module rccs_channel (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Requests toward interface module
  output logic cmd_start_o,
  output logic [7:0] cmd_code_o,
  output logic repeat_o,
  output logic cancel_req_o,
  output logic restart_req_o,
  // Answers from interface module
  input wire logic mod_ack_i,
  input wire logic mod_cancel_ack_i,
  input wire logic mod_error_i,
  input wire logic [7:0] mod_error_code_i,
  input wire logic mod_down_i,
  input wire logic bus_error_i,
  input wire logic [7:0] bus_error_code_i,
  // Tag condition from interface module
  input wire logic tag_present_i,
  input wire logic data_corrected_i,
  input wire logic dialog_battery_dead_i,
  input wire logic battery_low_i,
  // Parameter block loaded
  input wire logic param_load_i
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int IN_W = 26;
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] syn_in;
  logic ack_s, cack_s, merr_s, mdown_s, berr_s, tag_s, corr_s, bdead_s, blow_s, pload_s;
  logic [7:0] mcode_s, bcode_s;

  // All module-side pins are foreign to clk_i
  assign raw_in = {mod_ack_i, mod_cancel_ack_i, mod_error_i, mod_error_code_i, mod_down_i, bus_error_i,
                   bus_error_code_i, tag_present_i, data_corrected_i, dialog_battery_dead_i,
                   battery_low_i, param_load_i};
  assign {ack_s, cack_s, merr_s, mcode_s, mdown_s, berr_s, bcode_s, tag_s, corr_s, bdead_s, blow_s,
          pload_s} = syn_in;

  rccs_sync #(.W(IN_W)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(raw_in),
    .sync_o(syn_in)
  );

  // ----------------------------------------
  // State and event decode
  // ----------------------------------------
  rccs_pkg::rccs_state_t s_r;
  rccs_pkg::rccs_state_t s_nxt;
  logic wr_acc, rd_setup, ctrl_wr, addr_ok;
  logic ack_rise, cack_rise, merr_rise, mdown_rise, berr_rise, pload_rise;
  logic wr_start, wr_cancel, restart_ev, busy_cmd, start_ok;
  logic err_set, err_clr, abt_set, abt_clr;
  logic err_flag, abt_flag;

  // Bus phase and address decode
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign addr_ok = (paddr_i == `RCCS_OFS_CTRL) | (paddr_i == `RCCS_OFS_STATUS) |
                   (paddr_i == `RCCS_OFS_CODES);
  assign ctrl_wr = wr_acc & (paddr_i == `RCCS_OFS_CTRL);
  // Edge detect on second synchroniser stage only
  assign ack_rise = ack_s & ~s_r.ack_q;
  assign cack_rise = cack_s & ~s_r.cack_q;
  assign merr_rise = merr_s & ~s_r.merr_q;
  assign mdown_rise = mdown_s & ~s_r.mdown_q;
  assign berr_rise = berr_s & ~s_r.berr_q;
  assign pload_rise = pload_s & ~s_r.pload_q;
  // Software requests
  assign wr_start = ctrl_wr & pwdata_i[`RCCS_CTRL_START];
  assign wr_cancel = ctrl_wr & pwdata_i[`RCCS_CTRL_CANCEL];
  assign restart_ev = (ctrl_wr & pwdata_i[`RCCS_CTRL_RESTART]) | pload_rise;
  assign busy_cmd = (s_r.mode == rccs_pkg::RCCS_RUN) | (s_r.mode == rccs_pkg::RCCS_CANCEL);
  assign start_ok = wr_start & (s_r.mode == rccs_pkg::RCCS_IDLE) & ~s_r.mod_failed & ~restart_ev &
                    ~mdown_rise;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Events applied lowest priority first; later ones override, but an error flag set is kept over a later clear
  always_comb begin
    s_nxt = s_r;
    err_set = 1'b0;
    err_clr = 1'b0;
    abt_set = 1'b0;
    abt_clr = 1'b0;
    s_nxt.cmd_pulse = 1'b0;
    s_nxt.ack_q = ack_s;
    s_nxt.cack_q = cack_s;
    s_nxt.merr_q = merr_s;
    s_nxt.mdown_q = mdown_s;
    s_nxt.berr_q = berr_s;
    s_nxt.pload_q = pload_s;
    // Configuration writes
    if (ctrl_wr) begin
      s_nxt.repeat_en = pwdata_i[`RCCS_CTRL_REPEAT];
      s_nxt.mod_failed = pwdata_i[`RCCS_CTRL_FAILED];
      s_nxt.presence_en = pwdata_i[`RCCS_CTRL_PRESENCE];
      s_nxt.ecc_en = pwdata_i[`RCCS_CTRL_ECC];
    end
    s_nxt.tag_pres = s_r.presence_en & tag_s & (s_r.mode != rccs_pkg::RCCS_RESTART);
    s_nxt.bat_dead = bdead_s;
    s_nxt.bat_low = blow_s;
    // Mode sequencing on module answers
    case (s_r.mode)
      rccs_pkg::RCCS_IDLE: begin
        s_nxt.ready = 1'b1;
      end
      rccs_pkg::RCCS_RUN: begin
        if (ack_rise) begin
          s_nxt.mode = rccs_pkg::RCCS_IDLE;
          s_nxt.active = 1'b0;
          s_nxt.ready = 1'b1;
          s_nxt.last_adv = (s_r.cmd_code == `RCCS_CMD_ADVANCE);
          s_nxt.last_rst = 1'b0;
          s_nxt.corrected = s_r.ecc_en & corr_s;
        end
      end
      rccs_pkg::RCCS_CANCEL: begin
        if (cack_rise) begin
          s_nxt.mode = rccs_pkg::RCCS_IDLE;
          s_nxt.ready = 1'b1;
          abt_set = 1'b1;
        end
      end
      rccs_pkg::RCCS_RESTART: begin
        s_nxt.active = 1'b0;
        s_nxt.ready = 1'b0;
        if (ack_rise) begin
          s_nxt.mode = rccs_pkg::RCCS_IDLE;
          s_nxt.ready = 1'b1;
          s_nxt.last_rst = 1'b1;
          s_nxt.last_adv = 1'b0;
        end
      end
      default: begin
        s_nxt.mode = rccs_pkg::RCCS_RESTART;
      end
    endcase
    if (start_ok) begin
      s_nxt.mode = rccs_pkg::RCCS_RUN;
      s_nxt.cmd_code = pwdata_i[`RCCS_CTRL_CODE_HI:`RCCS_CTRL_CODE_LO];
      s_nxt.cmd_pulse = 1'b1;
      s_nxt.active = 1'b1;
      s_nxt.ready = 1'b0;
      s_nxt.corrected = 1'b0;
      s_nxt.mod_code = `RCCS_CODE_NONE;
      s_nxt.fn_code = `RCCS_CODE_NONE;
      s_nxt.bus_code = `RCCS_CODE_NONE;
      err_clr = 1'b1;
      abt_clr = 1'b1;
    end
    if (wr_cancel & (s_r.mode != rccs_pkg::RCCS_RESTART)) begin
      s_nxt.mode = rccs_pkg::RCCS_CANCEL;
      s_nxt.active = 1'b0;
      s_nxt.ready = 1'b0;
      s_nxt.repeat_en = 1'b0;
      s_nxt.cmd_pulse = 1'b0;
    end
    // module or bus error ends command
    if ((merr_rise | berr_rise) & busy_cmd) begin
      s_nxt.mode = rccs_pkg::RCCS_IDLE;
      s_nxt.active = 1'b0;
      s_nxt.ready = 1'b1;
      err_set = 1'b1;
      if (merr_rise) begin
        s_nxt.mod_code = mcode_s;
      end
      if (berr_rise) begin
        s_nxt.bus_code = bcode_s;
      end
    end
    // failed flag aborts with code 09
    if (s_r.mod_failed & busy_cmd) begin
      s_nxt.mode = rccs_pkg::RCCS_IDLE;
      s_nxt.active = 1'b0;
      s_nxt.ready = 1'b1;
      s_nxt.fn_code = `RCCS_FN_ERR_FAILED;
      err_set = 1'b1;
    end
    if (mdown_rise & (s_r.mode != rccs_pkg::RCCS_RESTART)) begin
      s_nxt.mode = rccs_pkg::RCCS_IDLE;
      s_nxt.active = 1'b0;
      s_nxt.ready = 1'b1;
      s_nxt.mod_code = `RCCS_MOD_ERR_DOWN;
      s_nxt.cmd_pulse = 1'b0;
      err_set = 1'b1;
    end
    if (restart_ev) begin
      s_nxt.mode = rccs_pkg::RCCS_RESTART;
      s_nxt.active = 1'b0;
      s_nxt.ready = 1'b0;
      s_nxt.repeat_en = 1'b0;
      s_nxt.cmd_pulse = 1'b0;
      s_nxt.mod_code = `RCCS_CODE_NONE;
      s_nxt.fn_code = `RCCS_CODE_NONE;
      s_nxt.bus_code = `RCCS_CODE_NONE;
      err_clr = 1'b1;
    end
    // Read data captured in setup so it is stable in access
    s_nxt.prdata = 32'h0000_0000;
    if (rd_setup & (paddr_i == `RCCS_OFS_CTRL)) begin
      s_nxt.prdata[`RCCS_CTRL_RESTART] = (s_r.mode == rccs_pkg::RCCS_RESTART);
      s_nxt.prdata[`RCCS_CTRL_REPEAT] = s_r.repeat_en;
      s_nxt.prdata[`RCCS_CTRL_FAILED] = s_r.mod_failed;
      s_nxt.prdata[`RCCS_CTRL_PRESENCE] = s_r.presence_en;
      s_nxt.prdata[`RCCS_CTRL_ECC] = s_r.ecc_en;
      s_nxt.prdata[`RCCS_CTRL_CODE_HI:`RCCS_CTRL_CODE_LO] = s_r.cmd_code;
    end else if (rd_setup & (paddr_i == `RCCS_OFS_STATUS)) begin
      s_nxt.prdata[`RCCS_ST_READY] = s_r.ready;
      s_nxt.prdata[`RCCS_ST_ACTIVE] = s_r.active;
      s_nxt.prdata[`RCCS_ST_ERROR] = err_flag;
      s_nxt.prdata[`RCCS_ST_ADVANCE] = s_r.last_adv;
      s_nxt.prdata[`RCCS_ST_RESTART] = s_r.last_rst;
      s_nxt.prdata[`RCCS_ST_TAG] = s_r.tag_pres;
      s_nxt.prdata[`RCCS_ST_ABORT] = abt_flag;
      s_nxt.prdata[`RCCS_ST_CORRECTED] = s_r.corrected;
      s_nxt.prdata[`RCCS_ST_BAT_DEAD] = s_r.bat_dead;
      s_nxt.prdata[`RCCS_ST_BAT_LOW] = s_r.bat_low;
      s_nxt.prdata[`RCCS_ST_CANCELING] = (s_r.mode == rccs_pkg::RCCS_CANCEL);
    end else if (rd_setup & (paddr_i == `RCCS_OFS_CODES)) begin
      s_nxt.prdata = {8'h00, s_r.bus_code, s_r.fn_code, s_r.mod_code};
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // reset comes up with restart pending
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.mode <= rccs_pkg::RCCS_RESTART;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Sticky error and abort indications
  rccs_flag u_err (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(err_set),
    .clr_i(err_clr),
    .flag_o(err_flag)
  );
  rccs_flag u_abt (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(abt_set),
    .clr_i(abt_clr),
    .flag_o(abt_flag)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Zero-wait slave; unmapped offsets answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign prdata_o = s_r.prdata;
  assign cmd_start_o = s_r.cmd_pulse;
  assign cmd_code_o = s_r.cmd_code;
  assign repeat_o = s_r.repeat_en;
  assign cancel_req_o = (s_r.mode == rccs_pkg::RCCS_CANCEL);
  assign restart_req_o = (s_r.mode == rccs_pkg::RCCS_RESTART);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence rccs_run_end_s;
    (s_r.mode == rccs_pkg::RCCS_RUN) && ack_rise && !wr_cancel && !merr_rise && !berr_rise &&
    !s_r.mod_failed && !mdown_rise && !restart_ev;
  endsequence
  restart_request_a: assert property (restart_ev |=> restart_req_o && !s_r.active && !s_r.ready)
    else $error("restart not taken");
  module_down_a: assert property (mdown_rise && !restart_ev && (s_r.mode != rccs_pkg::RCCS_RESTART)
    |=> (s_r.mod_code == 8'h0f) && err_flag)
    else $error("module failure code missing");
  failed_abort_a: assert property (s_r.mod_failed && busy_cmd && !restart_ev && !mdown_rise
    |=> (s_r.fn_code == 8'h09) && !s_r.active && err_flag)
    else $error("failed flag did not abort");
  active_hold_a: assert property (s_r.active && !ack_rise && !wr_cancel && !merr_rise && !berr_rise &&
    !s_r.mod_failed && !mdown_rise && !restart_ev |=> s_r.active)
    else $error("active dropped early");
  advance_flag_a: assert property (rccs_run_end_s ##0 (s_r.cmd_code == 8'h0b) |=> s_r.last_adv && s_r.ready)
    else $error("advance flag missing");
  restart_flag_a: assert property ((s_r.mode == rccs_pkg::RCCS_RESTART) && ack_rise && !restart_ev
    |=> s_r.last_rst && s_r.ready && !s_r.last_adv)
    else $error("restart flag missing");
  tag_gate_a: assert property (!s_r.presence_en || (s_r.mode == rccs_pkg::RCCS_RESTART) |=> !s_r.tag_pres)
    else $error("tag shown while gated");
  abort_flag_a: assert property ((s_r.mode == rccs_pkg::RCCS_CANCEL) && cack_rise && !restart_ev
    |=> abt_flag ##1 (abt_flag || $past(start_ok)))
    else $error("abort flag not held");
  start_clear_a: assert property (start_ok && !err_set && !wr_cancel
    |=> !err_flag && !s_r.ready && s_r.active && cmd_start_o)
    else $error("start did not clear status");
  cancel_ready_a: assert property (wr_cancel && busy_cmd && !restart_ev && !mdown_rise && !merr_rise &&
    !berr_rise && !s_r.mod_failed |=> cancel_req_o && !s_r.active)
    else $error("cancel not taken");

endmodule

// *** rccs_mod_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Interface module stand-in
// ----------------------------------------
module rccs_mod_model #(
  parameter logic [7:0] ERR_CODE = 8'h3c
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Requests from channel
  input wire logic cmd_start_i,
  input wire logic cancel_req_i,
  input wire logic restart_req_i,
  // Behaviour chosen by bench
  input wire logic [7:0] delay_i,
  input wire logic fail_i,
  // Answers to channel
  output logic ack_o,
  output logic cancel_ack_o,
  output logic error_o,
  output logic [7:0] error_code_o
);
  // Owed answer: 0 none, 1 ack, 2 cancel ack, 3 error, 4 restart ack
  logic [2:0] kind_r;
  logic [7:0] cnt_r;
  logic [3:0] hold_r;

  // Code held constant so it is stable long before any error strobe
  assign error_code_o = ERR_CODE;

  // Pulses last 5 cycles so the edge survives the synchroniser
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      kind_r <= 3'h0;
      cnt_r <= 8'h00;
      hold_r <= 4'h0;
      ack_o <= 1'b0;
      cancel_ack_o <= 1'b0;
      error_o <= 1'b0;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
      if (hold_r == 4'h1) begin
        ack_o <= 1'b0;
        cancel_ack_o <= 1'b0;
        error_o <= 1'b0;
      end
    end else if (restart_req_i && kind_r != 3'h4) begin
      kind_r <= 3'h4;
      cnt_r <= delay_i;
    end else if (cancel_req_i && kind_r != 3'h2) begin
      kind_r <= 3'h2;
      cnt_r <= delay_i;
    end else if (kind_r != 3'h0) begin
      if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end else begin
        ack_o <= (kind_r == 3'h1) || (kind_r == 3'h4);
        cancel_ack_o <= (kind_r == 3'h2);
        error_o <= (kind_r == 3'h3);
        hold_r <= 4'h5;
        kind_r <= 3'h0;
      end
    end else if (cmd_start_i) begin
      kind_r <= fail_i ? 3'h3 : 3'h1;
      cnt_r <= delay_i;
    end
  end
endmodule

// *** rccs_channel_tb_top.sv ***
`timescale 1ns/1ps
`include "rccs_regs.svh"

module rccs_channel_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [7:0] MOD_CODE = 8'h3c;
  localparam logic [7:0] BUS_CODE = 8'h5e;
  logic clk_i = 1'b0, sys_rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, cmd_start_o, repeat_o, cancel_req_o, restart_req_o;
  logic [7:0] cmd_code_o, mod_error_code_i, mdly = 8'h04, code;
  logic mod_ack_i, mod_cancel_ack_i, mod_error_i, mfail = 1'b0;
  logic mod_down_i = 1'b0, bus_error_i = 1'b0, param_load_i = 1'b0;
  logic [7:0] bus_error_code_i = 8'h00;
  logic tag_present_i = 1'b0, data_corrected_i = 1'b0;
  logic dialog_battery_dead_i = 1'b0, battery_low_i = 1'b0;
  logic [31:0] rd_q;
  logic err_q, dc;
  logic [3:0] cfg = 4'h0;
  int n_fail = 0;
  int total_checks = 0;

  // Free-running 10 MHz clock
  always #50 clk_i = ~clk_i;

  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  rccs_channel uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .cmd_start_o(cmd_start_o), .cmd_code_o(cmd_code_o), .repeat_o(repeat_o),
    .cancel_req_o(cancel_req_o), .restart_req_o(restart_req_o), .mod_ack_i(mod_ack_i),
    .mod_cancel_ack_i(mod_cancel_ack_i), .mod_error_i(mod_error_i), .mod_error_code_i(mod_error_code_i),
    .mod_down_i(mod_down_i), .bus_error_i(bus_error_i), .bus_error_code_i(bus_error_code_i),
    .tag_present_i(tag_present_i), .data_corrected_i(data_corrected_i),
    .dialog_battery_dead_i(dialog_battery_dead_i), .battery_low_i(battery_low_i), .param_load_i(param_load_i));

  rccs_mod_model #(.ERR_CODE(MOD_CODE)) model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cmd_start_i(cmd_start_o), .cancel_req_i(cancel_req_o), .restart_req_i(restart_req_o), .delay_i(mdly),
    .fail_i(mfail), .ack_o(mod_ack_i), .cancel_ack_o(mod_cancel_ack_i), .error_o(mod_error_i),
    .error_code_o(mod_error_code_i));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Config bits ride along with every control write
  task automatic ctrl(input logic [2:0] op, input logic [7:0] c);
    apb(1'b1, `RCCS_OFS_CTRL, {16'h0000, c, 1'b0, cfg, op});
  endtask

  task automatic st();
    apb(1'b0, `RCCS_OFS_STATUS, 32'h0);
  endtask

  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 150; i++) begin
      st();
      if (rd_q[b] === v) break;
    end
    check(rd_q[b], v);
  endtask

  function automatic logic [23:0] exp_codes(input int k);
    case (k)
      0: return {16'h0000, MOD_CODE};
      1: return {BUS_CODE, 16'h0000};
      default: return {8'h00, `RCCS_FN_ERR_FAILED, 8'h00};
    endcase
  endfunction

  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  // Watchdog well beyond the expected run length
  initial begin
    #3000000;
    n_fail++;
    stop_test();
  end

  initial begin
    void'($urandom(7692));
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // Startup restart, the host's first request
    ctrl(3'b100, 8'h00);
    poll(`RCCS_ST_READY, 1'b1);
    check(rd_q[10:0], 32'h011);
    // Random commands, the first one an advance
    for (int k = 0; k < 8; k++) begin
      code = (k == 0) ? `RCCS_CMD_ADVANCE : 8'($urandom_range(255));
      cfg = {1'($urandom_range(1)), 3'h0};
      dc = 1'($urandom_range(1));
      data_corrected_i <= dc;
      mdly <= 8'($urandom_range(20, 3));
      ctrl(3'b001, code);
      st();
      check(rd_q[2:0], 32'h2);
      check(cmd_code_o, code);
      poll(`RCCS_ST_READY, 1'b1);
      check(rd_q[3], code == `RCCS_CMD_ADVANCE);
      check(rd_q[2], 1'b0);
      check(rd_q[7], dc & cfg[3]);
    end
    // Presence gating, then restart in mid-command
    tag_present_i <= 1'b1;
    cfg = 4'h0;
    ctrl(3'b000, 8'h00);
    st();
    check(rd_q[5], 1'b0);
    cfg = 4'h4;
    ctrl(3'b000, 8'h00);
    st();
    check(rd_q[5], 1'b1);
    mdly <= 8'h3c;
    ctrl(3'b001, 8'h21);
    ctrl(3'b100, 8'h00);
    st();
    check(rd_q[5], 1'b0);
    check(rd_q[1], 1'b0);
    poll(`RCCS_ST_READY, 1'b1);
    check(rd_q[5:4], 32'h3);
    // Cancel while busy with repeat on, abort flag cleared by next start
    cfg = 4'h5;
    ctrl(3'b001, 8'h30);
    st();
    check(repeat_o, 1'b1);
    ctrl(3'b010, 8'h00);
    st();
    check(rd_q[1:0], 32'h0);
    check(rd_q[10], 1'b1);
    check(cancel_req_o, 1'b1);
    check(repeat_o, 1'b0);
    poll(`RCCS_ST_READY, 1'b1);
    check(rd_q[6], 1'b1);
    cfg = 4'h4;
    mdly <= 8'h05;
    ctrl(3'b001, 8'h31);
    st();
    check(rd_q[6], 1'b0);
    poll(`RCCS_ST_READY, 1'b1);
    // Module error, bus error, failed flag
    for (int k = 0; k < 3; k++) begin
      mfail <= (k == 0);
      mdly <= 8'h28;
      ctrl(3'b001, 8'h40);
      if (k == 1) begin
        bus_error_code_i <= BUS_CODE;
        repeat (4) @(posedge clk_i);
        bus_error_i <= 1'b1;
      end
      if (k == 2) begin
        cfg[1] = 1'b1;
        ctrl(3'b000, 8'h00);
      end
      poll(`RCCS_ST_ERROR, 1'b1);
      check(rd_q[1], 1'b0);
      apb(1'b0, `RCCS_OFS_CODES, 32'h0);
      check(rd_q[23:0], exp_codes(k));
      apb(1'b0, `RCCS_OFS_CTRL, 32'h0);
      check(rd_q[6:3], cfg);
      bus_error_i <= 1'b0;
      mfail <= 1'b0;
      mdly <= 8'h04;
      cfg = 4'h4;
      if (k == 0) begin
        ctrl(3'b001, 8'h41);
        st();
        check(rd_q[2], 1'b0);
        poll(`RCCS_ST_READY, 1'b1);
      end
      // Restart flushes whatever the module still owes
      ctrl(3'b100, 8'h00);
      poll(`RCCS_ST_READY, 1'b1);
    end
    // Module failure and host recovery
    mod_down_i <= 1'b1;
    poll(`RCCS_ST_ERROR, 1'b1);
    apb(1'b0, `RCCS_OFS_CODES, 32'h0);
    check(rd_q[7:0], `RCCS_MOD_ERR_DOWN);
    mod_down_i <= 1'b0;
    ctrl(3'b100, 8'h00);
    poll(`RCCS_ST_READY, 1'b1);
    check(rd_q[2], 1'b0);
    // Parameter load forces a restart
    mdly <= 8'h1e;
    param_load_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(restart_req_o, 1'b1);
    param_load_i <= 1'b0;
    poll(`RCCS_ST_READY, 1'b1);
    check(rd_q[4], 1'b1);
    // Battery flags pass straight through
    for (int k = 0; k < 4; k++) begin
      dialog_battery_dead_i <= k[0];
      battery_low_i <= k[1];
      repeat (4) @(posedge clk_i);
      st();
      check(rd_q[9:8], k[1:0]);
    end
    // Unmapped address answers with an error
    apb(1'b0, 12'h00c, 32'h0);
    check(err_q, 1'b1);
    stop_test();
  end
endmodule
